//--- logic/smb_pkg.sv
/*
 * Shared constants and types of the SMBus byte transfer engine.
 * Assumes a 100 MHz core clock and software on a plain register port.
 */
package smb_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS = 5000;
    localparam int SCL_HALF_CYC =
        (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SCL_HALF_CNT = 10'(SCL_HALF_CYC - 1);

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_OFS = 2'h0;
    localparam logic [1:0] DATA_OFS = 2'h1;
    localparam logic [1:0] CFG_OFS = 2'h2;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_INH_BIT = 1;
    localparam logic [7:0] REG_RST = 8'h00;

    // ------------------------------------------------------------
    // Byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle, st_start, st_bits, st_hold, st_stop
    } smb_fsm_type;

    // Layout of the control and status register, bit 7 down to bit 0
    typedef struct packed {
        logic master;
        logic transmit_direction_flag;
        logic start_request_flag;
        logic stop_request_flag;
        logic ack_value_needed_flag;
        logic arbitration_lost_flag;
        logic ack;
        logic si;
    } smb_flags_type;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smb_req_type;

    typedef struct packed {
        smb_fsm_type st;
        logic [1:0] ph;
        logic [9:0] cnt;
        logic [3:0] bcnt;
        smb_flags_type flags;
        logic [7:0] data;
        logic en;
        logic slave_event_inhibit;
        logic written;
        logic busy;
        logic addressed;
        logic addr_byte;
        logic suppress;
        logic scl_oe;
        logic sda_oe;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic [7:0] rdata;
        logic irq;
    } smb_reg_type;

endpackage

//--- logic/smb_engine.sv
/*
 * SMBus byte transfer engine: master and slave, transmit and receive.
 * Assumes open-drain SCL/SDA resolved outside from the enables, and a
 * register port whose strobes are one cycle long and never both high.
 */
// What this block does
// - Master flag: set on START, cleared STOP/arbitration
// - Direction set by START/early write, cleared otherwise
// - Start flag set on received START plus address
// - Stop flag: slave STOP or STOP arbitration loss
// - Ack-needed after received byte, cleared after ack
// - Arbitration lost: stray START or STOP, SCL low, SDA low
// - Transmitter stores received acknowledge level
// - Byte event flag set on each frame event
// - Data leaves MSB first, arrives MSB first
// - Bus level shifts in while shifting out
// - Lost master transmitter becomes slave receiver
// - Receiver interrupt before ack, transmitter after
// - Master transmit: START, address write, bytes, STOP
// - No data write after transmit: become receiver
// - Master receive: read address, ack-needed per byte
// - Acknowledge bit one sends ACK, zero NACK
// - Data write switches receiver to transmitter
// - Uninhibited slave address raises event and ack-needed
// - NACKed slave address silences slave until START
// - Slave receiver turns transmitter on data write
// - Slave transmitter reverts without write, STOP ends
`timescale 1ns/1ps

module smb_engine (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input smb_pkg::smb_req_type req_i,
    output logic [7:0] rdata_o,
    output logic byte_event_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    // ------------------------------------------------------------
    // Bus sampling
    // ------------------------------------------------------------
    smb_pkg::smb_reg_type q;
    smb_pkg::smb_reg_type d;
    smb_pkg::smb_flags_type wflags;
    logic scl_ok;
    logic sda_ok;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic tick;
    logic own;
    logic lose;
    logic next_byte;
    logic quiet;

    assign wflags = smb_pkg::smb_flags_type'(req_i.wdata);
    // A level counts once the second and third stages agree
    assign scl_ok = (q.scl_s[1] == q.scl_s[2]);
    assign sda_ok = (q.sda_s[1] == q.sda_s[2]);
    assign scl_rise = scl_ok && q.scl_s[2] && !q.scl_f;
    assign scl_fall = scl_ok && !q.scl_s[2] && q.scl_f;
    assign start_ev = sda_ok && !q.sda_s[2] && q.sda_f && q.scl_f;
    assign stop_ev = sda_ok && q.sda_s[2] && !q.sda_f && q.scl_f;
    assign tick = (q.cnt == smb_pkg::SCL_HALF_CNT);
    // Our own START and STOP must not be seen as someone else's
    assign own = (q.st == smb_pkg::st_start) || (q.st == smb_pkg::st_stop);
    assign quiet = q.en && !start_ev && !stop_ev && !req_i.wr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        lose = 1'b0;
        next_byte = 1'b0;
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        if (scl_ok) begin
            d.scl_f = q.scl_s[2];
        end
        if (sda_ok) begin
            d.sda_f = q.sda_s[2];
        end
        d.cnt = tick ? 10'h000 : q.cnt + 10'h001;
        d.rdata = smb_pkg::REG_RST;

        if (req_i.rd) begin
            if (req_i.addr == smb_pkg::CTRL_OFS) begin
                d.rdata = q.flags;
            end else if (req_i.addr == smb_pkg::DATA_OFS) begin
                d.rdata = q.data;
            end else if (req_i.addr == smb_pkg::CFG_OFS) begin
                d.rdata = {6'h00, q.slave_event_inhibit, q.en};
            end
        end
        if (req_i.wr) begin
            if (req_i.addr == smb_pkg::CTRL_OFS) begin
                d.flags.start_request_flag = wflags.start_request_flag;
                d.flags.stop_request_flag = wflags.stop_request_flag;
                d.flags.ack = wflags.ack;
                d.flags.si = wflags.si;
                if (!wflags.si) begin
                    d.flags.arbitration_lost_flag = 1'b0;
                end
            end else if (req_i.addr == smb_pkg::DATA_OFS) begin
                d.data = req_i.wdata;
                d.written = 1'b1;
                if (q.st == smb_pkg::st_idle) begin
                    d.flags.transmit_direction_flag = 1'b1;
                end
            end else if (req_i.addr == smb_pkg::CFG_OFS) begin
                d.en = req_i.wdata[smb_pkg::CFG_EN_BIT];
                d.slave_event_inhibit = req_i.wdata[smb_pkg::CFG_INH_BIT];
            end
        end

        // Hardware events come after software so that a set wins
        if (!q.en) begin
            d.st = smb_pkg::st_idle;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.busy = 1'b0;
        end else if (!own && start_ev) begin
            if (q.flags.master && !q.flags.start_request_flag) begin
                lose = 1'b1;
            end
            d.busy = 1'b1;
            d.flags.transmit_direction_flag = 1'b0;
            d.written = 1'b0;
            d.suppress = 1'b0;
            d.addressed = 1'b0;
            d.addr_byte = 1'b1;
            d.bcnt = 4'h0;
            d.st = smb_pkg::st_bits;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
        end else if (!own && stop_ev) begin
            d.busy = 1'b0;
            if (q.flags.master) begin
                lose = 1'b1;
                d.flags.stop_request_flag = 1'b1;
            end else if (q.addressed) begin
                d.flags.stop_request_flag = 1'b1;
                d.flags.si = 1'b1;
            end
            d.addressed = 1'b0;
            d.st = smb_pkg::st_idle;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
        end else begin
            case (q.st)
                smb_pkg::st_idle: begin
                    if (q.flags.start_request_flag && !q.busy) begin
                        d.st = smb_pkg::st_start;
                        d.ph = 2'h0;
                        d.cnt = 10'h000;
                    end
                end
                smb_pkg::st_start: begin
                    if (tick) begin
                        if (q.ph == 2'h0) begin
                            d.scl_oe = 1'b0;
                            d.ph = 2'h1;
                        end else if (q.ph == 2'h1) begin
                            // Wait here while someone stretches SCL
                            if (q.scl_f) begin
                                d.sda_oe = 1'b1;
                                d.ph = 2'h2;
                            end else begin
                                d.cnt = q.cnt;
                            end
                        end else if (!q.scl_f) begin
                            lose = 1'b1;
                            d.st = smb_pkg::st_idle;
                        end else begin
                            d.scl_oe = 1'b1;
                            d.flags.master = 1'b1;
                            d.flags.transmit_direction_flag = 1'b1;
                            d.flags.si = 1'b1;
                            d.busy = 1'b1;
                            d.bcnt = 4'h0;
                            d.addr_byte = 1'b1;
                            d.st = smb_pkg::st_hold;
                        end
                    end
                end
                smb_pkg::st_stop: begin
                    if (tick) begin
                        if (q.ph == 2'h0) begin
                            d.scl_oe = 1'b0;
                            d.ph = 2'h1;
                        end else if (q.ph == 2'h1) begin
                            if (q.scl_f) begin
                                d.sda_oe = 1'b0;
                                d.ph = 2'h2;
                            end else begin
                                d.cnt = q.cnt;
                            end
                        end else if (!q.scl_f) begin
                            lose = 1'b1;
                            d.st = smb_pkg::st_idle;
                        end else begin
                            d.flags.master = 1'b0;
                            d.flags.stop_request_flag = 1'b0;
                            d.busy = 1'b0;
                            d.ph = 2'h0;
                            d.st = q.flags.start_request_flag ? smb_pkg::st_start
                                               : smb_pkg::st_idle;
                        end
                    end
                end
                smb_pkg::st_hold: begin
                    // SCL is stretched until software clears the event
                    d.scl_oe = 1'b1;
                    d.cnt = 10'h000;
                    if (!q.flags.si) begin
                        if (q.bcnt == smb_pkg::ACK_BIT) begin
                            if (q.addr_byte && !q.flags.master
                                && !q.flags.ack) begin
                                d.suppress = 1'b1;
                                d.st = smb_pkg::st_idle;
                                d.scl_oe = 1'b0;
                                d.sda_oe = 1'b0;
                            end else begin
                                d.sda_oe = q.flags.ack;
                                d.st = smb_pkg::st_bits;
                            end
                        end else if (q.flags.master && q.flags.stop_request_flag) begin
                            d.st = smb_pkg::st_stop;
                            d.ph = 2'h0;
                            d.sda_oe = 1'b1;
                        end else if (q.flags.master && q.flags.start_request_flag) begin
                            d.st = smb_pkg::st_start;
                            d.ph = 2'h0;
                            d.sda_oe = 1'b0;
                        end else begin
                            next_byte = 1'b1;
                        end
                    end
                end
                smb_pkg::st_bits: begin
                    if (q.flags.master) begin
                        if (q.scl_oe) begin
                            if (tick) begin
                                d.scl_oe = 1'b0;
                            end
                        end else if (!q.scl_f) begin
                            d.cnt = 10'h000;
                        end else if (tick) begin
                            d.scl_oe = 1'b1;
                        end
                    end else begin
                        d.scl_oe = 1'b0;
                    end
                    if (scl_rise) begin
                        if (q.bcnt < smb_pkg::ACK_BIT) begin
                            d.data = {q.data[6:0], q.sda_f};
                            if (q.flags.transmit_direction_flag && !q.sda_oe
                                && !q.sda_f) begin
                                // Keep shifting as a receiver
                                lose = 1'b1;
                            end
                        end else if (q.flags.transmit_direction_flag) begin
                            d.flags.ack = !q.sda_f;
                            d.flags.si = 1'b1;
                        end
                    end
                    if (scl_fall) begin
                        if (q.bcnt < smb_pkg::LAST_BIT) begin
                            d.bcnt = q.bcnt + 4'h1;
                            d.sda_oe = q.flags.transmit_direction_flag && !q.data[7];
                        end else if (q.bcnt == smb_pkg::LAST_BIT) begin
                            d.bcnt = smb_pkg::ACK_BIT;
                            d.sda_oe = 1'b0;
                            if (q.flags.transmit_direction_flag) begin
                                d.sda_oe = 1'b0;
                            end else if (q.addr_byte && !q.flags.master
                                && (q.slave_event_inhibit || q.suppress)) begin
                                d.st = smb_pkg::st_idle;
                            end else begin
                                d.flags.si = 1'b1;
                                d.flags.ack_value_needed_flag = 1'b1;
                                d.scl_oe = 1'b1;
                                d.st = smb_pkg::st_hold;
                                if (q.addr_byte && !q.flags.master) begin
                                    d.flags.start_request_flag = 1'b1;
                                    d.addressed = 1'b1;
                                end
                            end
                        end else begin
                            d.flags.ack_value_needed_flag = 1'b0;
                            // Clear the count so the hold never re-drives ack
                            d.bcnt = 4'h0;
                            d.sda_oe = 1'b0;
                            d.addr_byte = 1'b0;
                            d.scl_oe = 1'b1;
                            d.cnt = 10'h000;
                            if (q.flags.transmit_direction_flag) begin
                                d.st = smb_pkg::st_hold;
                            end else if (q.flags.master && q.flags.stop_request_flag) begin
                                d.st = smb_pkg::st_stop;
                                d.ph = 2'h0;
                                d.sda_oe = 1'b1;
                            end else if (q.flags.master && q.flags.start_request_flag) begin
                                d.st = smb_pkg::st_start;
                                d.ph = 2'h0;
                            end else begin
                                next_byte = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    d.st = smb_pkg::st_idle;
                end
            endcase
        end

        // Direction of the coming byte follows whether data was loaded
        if (next_byte) begin
            d.st = smb_pkg::st_bits;
            d.bcnt = 4'h0;
            d.flags.transmit_direction_flag = q.written;
            d.written = 1'b0;
            d.sda_oe = q.written && !q.data[7];
            d.cnt = 10'h000;
        end
        if (lose) begin
            d.flags.arbitration_lost_flag = 1'b1;
            d.flags.master = 1'b0;
            d.flags.transmit_direction_flag = 1'b0;
            d.flags.si = 1'b1;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end
        d.irq = d.flags.si;
    end

    // Reset leaves everything cleared, engine idle and pins released
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign byte_event_o = q.irq;
    assign scl_oe_o = q.scl_oe;
    assign sda_oe_o = q.sda_oe;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence rx_last_fall;
        q.st == smb_pkg::st_bits && scl_fall && quiet
            && q.bcnt == smb_pkg::LAST_BIT && !q.flags.transmit_direction_flag
            && !q.addr_byte;
    endsequence
    sequence ack_done;
        q.st == smb_pkg::st_bits && scl_fall && quiet
            && q.bcnt == smb_pkg::ACK_BIT;
    endsequence
    sequence data_rise;
        q.st == smb_pkg::st_bits && scl_rise && quiet
            && q.bcnt < smb_pkg::ACK_BIT;
    endsequence

    master_on_start_a: assert property (
        $rose(q.flags.master) |-> $past(q.st) == smb_pkg::st_start)
        else $error("master flag rose outside START");
    master_off_a: assert property (
        $fell(q.flags.master) && !$past(rst_i)
            |-> $past(q.st) == smb_pkg::st_stop || q.flags.arbitration_lost_flag)
        else $error("master flag fell without STOP or loss");
    rx_event_a: assert property (
        rx_last_fall |=> q.flags.si && q.flags.ack_value_needed_flag
            && q.st == smb_pkg::st_hold && q.scl_oe)
        else $error("receiver event missing before ack");
    ack_value_needed_flag_clear_a: assert property (
        ack_done |=> !q.flags.ack_value_needed_flag)
        else $error("ack-needed not cleared after ack");
    msb_out_a: assert property (
        q.st == smb_pkg::st_bits && scl_fall && quiet
            && q.bcnt < smb_pkg::LAST_BIT && q.flags.transmit_direction_flag
            |=> q.sda_oe == !q.data[7])
        else $error("wrong bit driven");
    shift_in_a: assert property (
        data_rise |=> q.data == {$past(q.data[6:0]), $past(q.sda_f)})
        else $error("bus level not shifted in");
    tx_ack_a: assert property (
        q.st == smb_pkg::st_bits && scl_rise && quiet
            && q.bcnt == smb_pkg::ACK_BIT && q.flags.transmit_direction_flag
            |=> q.flags.ack == !$past(q.sda_f) && q.flags.si)
        else $error("acknowledge not captured");
    arb_data_a: assert property (
        data_rise ##0 (q.flags.transmit_direction_flag && !q.sda_oe && !q.sda_f)
            |=> q.flags.arbitration_lost_flag && !q.flags.master && !q.flags.transmit_direction_flag)
        else $error("lost arbitration not flagged");
    ack_drive_a: assert property (
        q.st == smb_pkg::st_hold && !q.flags.si && quiet
            && q.bcnt == smb_pkg::ACK_BIT && q.flags.ack
            |=> q.sda_oe ##1 q.sda_oe)
        else $error("ACK not driven");
    stop_done_a: assert property (
        $fell(q.flags.stop_request_flag) && !$past(req_i.wr) && !$past(rst_i)
            |-> $past(q.st) == smb_pkg::st_stop)
        else $error("stop flag cleared without STOP");

endmodule // smb_engine

//--- verification/smb_slave_model.sv
/*
 * Far-side SMBus slave: acks every byte it is sent, answers reads.
 * Assumes a pulled-up wire that the bench resolves from all enables.
 */
`timescale 1ns/1ps

module smb_slave_model #(
    parameter logic [7:0] TX_BYTE = 8'h96
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic [7:0] got_o,
    output logic stopped_o
);
    // ------------------------------------------------------------
    // Bit engine; SDA only moves while SCL is low
    // ------------------------------------------------------------
    logic [7:0] sh = 8'h00;
    int n = 0;
    logic tx = 1'b0;
    logic first = 1'b0;
    logic nak = 1'b0;
    initial begin
        sda_oe_o = 1'b0;
        got_o = 8'h00;
        stopped_o = 1'b1;
    end
    always @(negedge sda_i) if (scl_i) begin
        n = 0;
        tx = 1'b0;
        first = 1'b1;
        stopped_o = 1'b0;
    end
    always @(posedge sda_i) if (scl_i) stopped_o = 1'b1;
    always @(posedge scl_i) if (!stopped_o) begin
        if (n < 8) sh = {sh[6:0], sda_i};
        if (n == 8) nak = sda_i;
        n = n + 1;
    end
    // A master NACK ends our sending; released SDA floats high
    // SDA moves well after SCL falls, so no false START is seen
    always @(negedge scl_i) if (!stopped_o) begin
        if (n == 9 && nak) tx = 1'b0;
        if (n == 9) n = 0;
        if (n == 8 && !tx) got_o = sh;
        sda_oe_o <= #300 tx ? (n < 8 && !TX_BYTE[7-n]) : (n == 8);
        if (n == 8 && first) tx = sh[0];
        if (n == 8) first = 1'b0;
    end
endmodule  // smb_slave_model

//--- verification/tb_top.sv
/*
 * Self-checking bench for the SMBus engine acting as a master.
 * Assumes the slave model on the far side of a pulled-up bus.
 */
`timescale 1ns/1ps

module tb_top;
    // ------------------------------------------------------------
    // Clock, reset and bus wires
    // ------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    smb_pkg::smb_req_type req = '0;
    logic [7:0] rdata, got, v;
    logic ev, scl_oe, sda_oe, m_sda_oe, stopped;
    wire logic scl_w = ~scl_oe;
    wire logic sda_w = ~(sda_oe | m_sda_oe);
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    // Rows: write flag, address, write data, expected read
    logic [18:0] rows [5] = '{
        {1'b0, 2'h0, 8'h00, 8'h00}, {1'b0, 2'h1, 8'h00, 8'h00},
        {1'b1, 2'h3, 8'hff, 8'h00}, {1'b1, 2'h1, 8'h5a, 8'h5a},
        {1'b0, 2'h0, 8'h00, 8'h40}};

    initial forever #5 core_clk_i = ~core_clk_i;

    smb_engine smb_engine_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata), .byte_event_o(ev),
        .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
        .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
    smb_slave_model smb_slave_model_i (.scl_i(scl_w), .sda_i(sda_w),
        .sda_oe_o(m_sda_oe), .got_o(got), .stopped_o(stopped));

    // ------------------------------------------------------------
    // Register port and checking tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        req <= '0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        req <= '0;
        #1 d = rdata;
        @(posedge core_clk_i);
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for the event, or for the slave to see a STOP
    task automatic wait_for(input logic stop);
        for (int i = 0; i < 20000; i++) begin
            @(posedge core_clk_i);
            if ((stop ? stopped : ev) === 1'b1) break;
        end
        // The engine ends its STOP one half period after the wire shows it
        if (stop) repeat (smb_pkg::SCL_HALF_CYC + 8) @(posedge core_clk_i);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        foreach (rows[k]) begin
            if (rows[k][18]) wr(rows[k][17:16], rows[k][15:8]);
            rd(rows[k][17:16], v);
            chk("row", rows[k][7:0], v);
        end
        wr(2'h2, 8'h01);
        wr(2'h0, 8'h20);
        wait_for(1'b0);
        rd(2'h0, v);
        chk("start", 8'he1, v & 8'hfd);
        wr(2'h1, 8'ha4);
        wr(2'h0, 8'h00);
        wait_for(1'b0);
        rd(2'h0, v);
        chk("addr ack", 8'hc3, v);
        chk("addr byte", 8'ha4, got);
        wr(2'h1, 8'h3c);
        wr(2'h0, 8'h00);
        wait_for(1'b0);
        rd(2'h1, v);
        chk("data reg", 8'h3c, v);
        chk("data byte", 8'h3c, got);
        wr(2'h0, 8'h10);
        wait_for(1'b1);
        rd(2'h0, v);
        chk("after stop", 8'h00, v & 8'hbc);
        wr(2'h0, 8'h20);
        wait_for(1'b0);
        wr(2'h1, 8'ha5);
        wr(2'h0, 8'h00);
        wait_for(1'b0);
        wr(2'h0, 8'h00);
        wait_for(1'b0);
        rd(2'h0, v);
        chk("rx event", 8'h89, v & 8'hfd);
        chk("scl held", 8'h00, {7'h00, scl_w});
        rd(2'h1, v);
        chk("rx byte", 8'h96, v);
        wr(2'h0, 8'h02);
        wait_for(1'b0);
        rd(2'h0, v);
        chk("rx event 2", 8'h89, v & 8'hfd);
        rd(2'h1, v);
        chk("rx byte 2", 8'h96, v);
        wr(2'h0, 8'h10);
        wait_for(1'b1);
        rd(2'h0, v);
        chk("rx stop", 8'h00, v & 8'hbc);
        // Reset in mid-run must clear the set-up and release both pins
        wr(2'h2, 8'h03);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(2'h2, v);
        chk("cfg after reset", 8'h00, v);
        chk("pins after reset", 8'h00, {6'h00, scl_oe, sda_oe});
        close_out();
    end
endmodule  // tb_top
